// ### ssf_params.svh
// Constants for the supply status, fault and command unit.
// Assumes inclusion by bare name from every design file except the package.
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

`define SSF_COND_W      12
`define SSF_UNUSED_BIT  2
`define SSF_VAL_W       16
`define SSF_MASK_RST    12'h000
`define SSF_VAL_RST     16'h0000
`define SSF_CAL_HI_VAL  16'hf000
`define SSF_CAL_LO_VAL  16'h1000

`endif

// ### ssf_pkg.sv
// Types shared by the supply status, fault and command unit.
// Assumes a command decoder ahead of it delivering tokenised commands.
package ssf_pkg;

    typedef enum logic [3:0] {
        SSF_OP_NOP         = 4'h0,
        SSF_OP_STATUS_Q    = 4'h1,
        SSF_OP_APPLY_HELD  = 4'h2,
        SSF_OP_REPORTING_MASK_QUERY_NAME = 4'h3,
        SSF_OP_REPORTING_MASK_QUERY_ALL  = 4'h4,
        SSF_OP_REPORTING_MASK_QUERY_NONE = 4'h5,
        SSF_OP_REPORTING_MASK_QUERY_NUM  = 4'h6,
        SSF_OP_MASK_Q      = 4'h7,
        SSF_OP_ACCUM_Q     = 4'h8,
        SSF_OP_FAULT_Q     = 4'h9,
        SSF_OP_SET_V       = 4'ha,
        SSF_OP_SET_I       = 4'hb,
        SSF_OP_CAL_MODE    = 4'hc,
        SSF_OP_CAL_HI      = 4'hd,
        SSF_OP_CAL_LO      = 4'he,
        SSF_OP_CAL_COMPUTE = 4'hf
    } ssf_op_t;

    typedef enum logic [1:0] {
        SSF_RESP_STATUS = 2'h0,
        SSF_RESP_MASK   = 2'h1,
        SSF_RESP_ACCUM  = 2'h2,
        SSF_RESP_FAULT  = 2'h3
    } ssf_resp_t;

endpackage : ssf_pkg

// ### ssf_cond_if.sv
// Condition register carrier between command unit and tracker.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`include "ssf_params.svh"

interface ssf_cond_if;
    logic [`SSF_COND_W-1:0] status;
    logic [`SSF_COND_W-1:0] fault;
    logic [`SSF_COND_W-1:0] accum;
    logic [`SSF_COND_W-1:0] mask;
    logic                   fault_clr;
    logic                   accum_clr;

    modport tracker (output status, output fault, output accum,
                     input mask, input fault_clr, input accum_clr);
    modport ctrl    (input status, input fault, input accum,
                     output mask, output fault_clr, output accum_clr);
endinterface : ssf_cond_if

// ### ssf_cond_tracker.sv
// Status, fault and accumulated status registers.
// Assumes cond_in comes from pins outside the ref_clk domain.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_cond_tracker (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic [`SSF_COND_W-1:0] cond_in,
    ssf_cond_if.tracker                 cif
);
    localparam logic [`SSF_COND_W-1:0] USED =
        ~(`SSF_COND_W'(1) << `SSF_UNUSED_BIT);

    logic [`SSF_COND_W-1:0] s1_reg;
    logic [`SSF_COND_W-1:0] s2_reg;
    logic [`SSF_COND_W-1:0] s3_reg;
    logic [`SSF_COND_W-1:0] status_reg;
    logic [`SSF_COND_W-1:0] status_next;
    logic [`SSF_COND_W-1:0] fault_reg;
    logic [`SSF_COND_W-1:0] accum_reg;
    logic [`SSF_COND_W-1:0] rise;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= `SSF_MASK_RST;
            s2_reg <= `SSF_MASK_RST;
            s3_reg <= `SSF_MASK_RST;
        end else begin
            s1_reg <= cond_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Bit follows its condition once two stages agree; spare bit stays 0
    assign status_next = ((s2_reg & s3_reg) |
                          (status_reg & (s2_reg ^ s3_reg))) & USED;
    assign rise = status_next & ~status_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= `SSF_MASK_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_reg <= `SSF_MASK_RST;
        end else begin
            fault_reg <= (fault_reg & ~{`SSF_COND_W{cif.fault_clr}}) |
                         (rise & cif.mask);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_reg <= `SSF_MASK_RST;
        end else begin
            accum_reg <= (accum_reg & ~{`SSF_COND_W{cif.accum_clr}}) |
                         status_next;
        end
    end

    assign cif.status = status_reg;
    assign cif.fault  = fault_reg;
    assign cif.accum  = accum_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_fault_edge;
        @(posedge ref_clk) disable iff (!rst_b)
        (rise[0] && cif.mask[0]) |=> fault_reg[0];
    endproperty
    a_fault_edge: assert property (p_fault_edge)
        else $error("masked rising condition did not set fault");

    property p_fault_no_mask;
        @(posedge ref_clk) disable iff (!rst_b)
        (!fault_reg[3] && !cif.mask[3]) |=> !fault_reg[3];
    endproperty
    a_fault_no_mask: assert property (p_fault_no_mask)
        else $error("fault bit set while its condition was masked");

    property p_status_follow;
        @(posedge ref_clk) disable iff (!rst_b)
        (cond_in[0] ##1 cond_in[0] ##1 cond_in[0] ##1 cond_in[0])
            |=> status_reg[0];
    endproperty
    a_status_follow: assert property (p_status_follow)
        else $error("status bit did not follow a steady condition");

    property p_status_drop;
        @(posedge ref_clk) disable iff (!rst_b)
        (!cond_in[1] [*4]) |=> !status_reg[1];
    endproperty
    a_status_drop: assert property (p_status_drop)
        else $error("status bit stayed set after condition ended");

    property p_spare_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        !status_reg[`SSF_UNUSED_BIT] && !accum_reg[`SSF_UNUSED_BIT];
    endproperty
    a_spare_zero: assert property (p_spare_zero)
        else $error("unused condition bit is set");

    property p_accum_keep;
        @(posedge ref_clk) disable iff (!rst_b)
        (status_reg[0] && !cif.accum_clr) |=> accum_reg[0];
    endproperty
    a_accum_keep: assert property (p_accum_keep)
        else $error("accumulated register lost an active condition");
endmodule : ssf_cond_tracker

// ### ssf_cmd_unit.sv
// Command unit for status, fault, hold/trigger and voltage calibration.
// Assumes a decoder delivers one token per cmd_valid and turns replies
// into text; hold_en and cmd_* come from ref_clk logic.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_cmd_unit #(
    parameter int COND_W = `SSF_COND_W,
    parameter int VAL_W  = `SSF_VAL_W
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic [COND_W-1:0]      cond_in,
    input  wire logic                   cmd_valid,
    input  wire ssf_pkg::ssf_op_t       cmd_op,
    input  wire logic                   cmd_last,
    input  wire logic [VAL_W-1:0]       cmd_arg_a,
    input  wire logic [VAL_W-1:0]       cmd_arg_b,
    input  wire logic                   hold_en,
    output logic                        resp_valid,
    output ssf_pkg::ssf_resp_t          resp_kind,
    output logic [COND_W-1:0]           resp_value,
    output logic                        cmd_error,
    output logic [VAL_W-1:0]            v_prog,
    output logic [VAL_W-1:0]            i_prog,
    output logic                        cal_mode,
    output logic                        cal_drive_en,
    output logic [VAL_W-1:0]            cal_drive_val,
    output logic [VAL_W-1:0]            v_slope,
    output logic [VAL_W-1:0]            v_offset
);
    ssf_cond_if cif ();

    ssf_cond_tracker u_tracker (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .cond_in (cond_in),
        .cif     (cif)
    );

    // Spare bit never enters the mask
    function automatic logic [COND_W-1:0] used_bits(
        input logic [COND_W-1:0] v);
        used_bits = v & ~(COND_W'(1) << `SSF_UNUSED_BIT);
    endfunction : used_bits

    function automatic logic [COND_W-1:0] name_bit(
        input logic [VAL_W-1:0] idx);
        name_bit = (idx < VAL_W'(COND_W)) ?
                   used_bits(COND_W'(1) << idx[3:0]) : '0;
    endfunction : name_bit

    logic                    go;
    logic [COND_W-1:0]       mask_reg;
    logic [COND_W-1:0]       stage_reg;
    logic                    stage_open_reg;
    logic [COND_W-1:0]       stage_base;
    logic [COND_W-1:0]       stage_next;
    logic                    is_reporting_mask_query;
    logic                    resp_valid_reg;
    ssf_pkg::ssf_resp_t      resp_kind_reg;
    logic [COND_W-1:0]       resp_value_reg;
    logic                    err_reg;
    logic [VAL_W-1:0]        v_reg;
    logic [VAL_W-1:0]        i_reg;
    logic [VAL_W-1:0]        v_held_reg;
    logic [VAL_W-1:0]        i_held_reg;
    logic                    cal_mode_reg;
    logic                    drive_en_reg;
    logic [VAL_W-1:0]        drive_val_reg;
    logic [VAL_W-1:0]        slope_reg;
    logic [VAL_W-1:0]        offset_reg;

    assign go = cmd_valid;

    // ************************************************************
    // Reporting mask
    // ************************************************************
    // Tokens of one command build up in a stage; mask changes at the end
    assign is_reporting_mask_query = (cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NAME) ||
                       (cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_ALL)  ||
                       (cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NONE) ||
                       (cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NUM);
    assign stage_base = stage_open_reg ? stage_reg : '0;

    always_comb begin
        stage_next = stage_base;
        case (cmd_op)
            ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NAME: begin
                stage_next = stage_base | name_bit(cmd_arg_a);
            end
            ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_ALL: begin
                stage_next = used_bits('1);
            end
            ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NONE: begin
                stage_next = '0;
            end
            ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NUM: begin
                stage_next = stage_base |
                             used_bits(cmd_arg_a[COND_W-1:0]);
            end
            default: begin
                stage_next = stage_base;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg       <= `SSF_MASK_RST;
            stage_reg      <= `SSF_MASK_RST;
            stage_open_reg <= 1'b0;
        end else if (go && is_reporting_mask_query) begin
            stage_reg      <= stage_next;
            stage_open_reg <= !cmd_last;
            if (cmd_last) begin
                mask_reg <= stage_next;
            end
        end
    end

    assign cif.mask      = mask_reg;
    assign cif.fault_clr = go && (cmd_op == ssf_pkg::SSF_OP_FAULT_Q);
    assign cif.accum_clr = go && (cmd_op == ssf_pkg::SSF_OP_ACCUM_Q);

    // ************************************************************
    // Replies
    // ************************************************************
    // Weighted sum equals the bit vector; text conversion is downstream
    // Bit n weighs two to the n, so the vector is the sum
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            resp_valid_reg <= 1'b0;
            resp_kind_reg  <= ssf_pkg::SSF_RESP_STATUS;
            resp_value_reg <= `SSF_MASK_RST;
        end else begin
            resp_valid_reg <= 1'b0;
            if (go) begin
                case (cmd_op)
                    ssf_pkg::SSF_OP_STATUS_Q: begin
                        resp_valid_reg <= 1'b1;
                        resp_kind_reg  <= ssf_pkg::SSF_RESP_STATUS;
                        resp_value_reg <= cif.status;
                    end
                    ssf_pkg::SSF_OP_MASK_Q: begin
                        resp_valid_reg <= 1'b1;
                        resp_kind_reg  <= ssf_pkg::SSF_RESP_MASK;
                        resp_value_reg <= mask_reg;
                    end
                    ssf_pkg::SSF_OP_ACCUM_Q: begin
                        resp_valid_reg <= 1'b1;
                        resp_kind_reg  <= ssf_pkg::SSF_RESP_ACCUM;
                        resp_value_reg <= cif.accum;
                    end
                    ssf_pkg::SSF_OP_FAULT_Q: begin
                        resp_valid_reg <= 1'b1;
                        resp_kind_reg  <= ssf_pkg::SSF_RESP_FAULT;
                        resp_value_reg <= cif.fault;
                    end
                    default: begin
                        resp_valid_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Settings, hold and trigger
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            v_reg      <= `SSF_VAL_RST;
            i_reg      <= `SSF_VAL_RST;
            v_held_reg <= `SSF_VAL_RST;
            i_held_reg <= `SSF_VAL_RST;
        end else if (go) begin
            if (cmd_op == ssf_pkg::SSF_OP_SET_V) begin
                v_held_reg <= cmd_arg_a;
                if (!hold_en) begin
                    v_reg <= cmd_arg_a;
                end
            end
            if (cmd_op == ssf_pkg::SSF_OP_SET_I) begin
                i_held_reg <= cmd_arg_a;
                if (!hold_en) begin
                    i_reg <= cmd_arg_a;
                end
            end
            if (cmd_op == ssf_pkg::SSF_OP_APPLY_HELD) begin
                v_reg <= v_held_reg;
                i_reg <= i_held_reg;
            end
        end
    end

    // ************************************************************
    // Voltage calibration
    // ************************************************************
    // Arithmetic kept to a difference; the scaling lives in firmware
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_mode_reg  <= 1'b0;
            drive_en_reg  <= 1'b0;
            drive_val_reg <= `SSF_VAL_RST;
            slope_reg     <= `SSF_VAL_RST;
            offset_reg    <= `SSF_VAL_RST;
        end else if (go) begin
            case (cmd_op)
                ssf_pkg::SSF_OP_CAL_MODE: begin
                    cal_mode_reg <= cmd_arg_a[0];
                    if (!cmd_arg_a[0]) begin
                        drive_en_reg <= 1'b0;
                    end
                end
                ssf_pkg::SSF_OP_CAL_HI: begin
                    if (cal_mode_reg) begin
                        drive_en_reg  <= 1'b1;
                        drive_val_reg <= `SSF_CAL_HI_VAL;
                    end
                end
                ssf_pkg::SSF_OP_CAL_LO: begin
                    if (cal_mode_reg) begin
                        drive_en_reg  <= 1'b1;
                        drive_val_reg <= `SSF_CAL_LO_VAL;
                    end
                end
                ssf_pkg::SSF_OP_CAL_COMPUTE: begin
                    if (cal_mode_reg) begin
                        slope_reg    <= cmd_arg_b - cmd_arg_a;
                        offset_reg   <= cmd_arg_a;
                        drive_en_reg <= 1'b0;
                    end
                end
                default: begin
                    drive_en_reg <= drive_en_reg;
                end
            endcase
        end
    end

    // Calibration commands outside calibration mode are refused
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= go && !cal_mode_reg &&
                       (cmd_op == ssf_pkg::SSF_OP_CAL_HI ||
                        cmd_op == ssf_pkg::SSF_OP_CAL_LO ||
                        cmd_op == ssf_pkg::SSF_OP_CAL_COMPUTE);
        end
    end

    assign resp_valid    = resp_valid_reg;
    assign resp_kind     = resp_kind_reg;
    assign resp_value    = resp_value_reg;
    assign cmd_error     = err_reg;
    assign v_prog        = v_reg;
    assign i_prog        = i_reg;
    assign cal_mode      = cal_mode_reg;
    assign cal_drive_en  = drive_en_reg;
    assign cal_drive_val = drive_val_reg;
    assign v_slope       = slope_reg;
    assign v_offset      = offset_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_status_reply;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cmd_op == ssf_pkg::SSF_OP_STATUS_Q)
            |=> (resp_valid && resp_value == $past(cif.status));
    endproperty
    a_status_reply: assert property (p_status_reply)
        else $error("status reply missing or wrong");

    property p_mask_reply;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cmd_op == ssf_pkg::SSF_OP_MASK_Q)
            |=> (resp_valid && resp_kind == ssf_pkg::SSF_RESP_MASK &&
                 resp_value == $past(mask_reg));
    endproperty
    a_mask_reply: assert property (p_mask_reply)
        else $error("mask reply missing or wrong");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && hold_en && cmd_op == ssf_pkg::SSF_OP_SET_V)
            |=> (v_prog == $past(v_reg));
    endproperty
    a_hold: assert property (p_hold)
        else $error("held voltage took effect before apply");

    property p_apply;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cmd_op == ssf_pkg::SSF_OP_APPLY_HELD)
            |=> (v_prog == $past(v_held_reg) && i_prog == $past(i_held_reg));
    endproperty
    a_apply: assert property (p_apply)
        else $error("apply did not load held settings");

    property p_reporting_mask_query_all;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_ALL && cmd_last)
            |=> (mask_reg == used_bits('1));
    endproperty
    a_reporting_mask_query_all: assert property (p_reporting_mask_query_all)
        else $error("all keyword did not enable every condition");

    property p_reporting_mask_query_num;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cmd_op == ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NUM && cmd_last &&
         !stage_open_reg)
            |=> (mask_reg == used_bits($past(cmd_arg_a[COND_W-1:0])));
    endproperty
    a_reporting_mask_query_num: assert property (p_reporting_mask_query_num)
        else $error("numeric reporting_mask_query gave wrong mask");

    property p_cal_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && !cal_mode_reg && cmd_op == ssf_pkg::SSF_OP_CAL_COMPUTE)
            |=> ($stable(v_slope) && cmd_error);
    endproperty
    a_cal_gate: assert property (p_cal_gate)
        else $error("compute ran outside calibration mode");

    property p_cal_hi;
        @(posedge ref_clk) disable iff (!rst_b)
        (go && cal_mode_reg && cmd_op == ssf_pkg::SSF_OP_CAL_HI)
            |=> (cal_drive_en && cal_drive_val == `SSF_CAL_HI_VAL);
    endproperty
    a_cal_hi: assert property (p_cal_hi)
        else $error("high point not driven");
endmodule : ssf_cmd_unit

// ### ssf_host_model.sv
// Host side model: issues command tokens one per call.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_host_model (
    input  wire logic                   ref_clk,
    output logic                        cmd_valid,
    output ssf_pkg::ssf_op_t            cmd_op,
    output logic                        cmd_last,
    output logic [`SSF_VAL_W-1:0]       cmd_arg_a,
    output logic [`SSF_VAL_W-1:0]       cmd_arg_b
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = ssf_pkg::SSF_OP_NOP;
        cmd_last  = 1'b1;
        cmd_arg_a = 16'h0000;
        cmd_arg_b = 16'h0000;
    end

    // Bench sends compute once with calibration mode off, then with it on
    task automatic send(input ssf_pkg::ssf_op_t op,
                        input logic [`SSF_VAL_W-1:0] a,
                        input logic [`SSF_VAL_W-1:0] b,
                        input logic l);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_last  <= l;
        cmd_arg_a <= a;
        cmd_arg_b <= b;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        // Released args inverted so stale data never looks valid
        cmd_arg_a <= ~a;
        cmd_arg_b <= ~b;
    endtask : send
endmodule : ssf_host_model

// ### test_ssf_cmd_unit.sv
// Self-checking bench for the command unit.
// Assumes the host model drives the command port.
`timescale 1ns/1ps
`include "ssf_params.svh"

module test_ssf_cmd_unit;
    logic ref_clk, rst_b, hold_en, cmd_valid, cmd_last;
    logic resp_valid, cmd_error, cal_mode, cal_drive_en;
    logic [11:0] cond_in, resp_value;
    logic [15:0] cmd_arg_a, cmd_arg_b, v_prog, i_prog;
    logic [15:0] cal_drive_val, v_slope, v_offset;
    ssf_pkg::ssf_op_t   cmd_op;
    ssf_pkg::ssf_resp_t resp_kind;
    int n_fail;
    int n_checks;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ssf_host_model u_ssf_host_model (.ref_clk(ref_clk),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_last(cmd_last),
        .cmd_arg_a(cmd_arg_a), .cmd_arg_b(cmd_arg_b));

    ssf_cmd_unit u_ssf_cmd_unit (.ref_clk(ref_clk), .rst_b(rst_b),
        .cond_in(cond_in), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_last(cmd_last), .cmd_arg_a(cmd_arg_a),
        .cmd_arg_b(cmd_arg_b), .hold_en(hold_en),
        .resp_valid(resp_valid), .resp_kind(resp_kind),
        .resp_value(resp_value), .cmd_error(cmd_error),
        .v_prog(v_prog), .i_prog(i_prog), .cal_mode(cal_mode),
        .cal_drive_en(cal_drive_en), .cal_drive_val(cal_drive_val),
        .v_slope(v_slope), .v_offset(v_offset));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Query, then check the one-cycle reply after the taking edge
    task automatic q(input ssf_pkg::ssf_op_t op, input logic [1:0] k,
                     input logic [11:0] e);
        u_ssf_host_model.send(op, 16'h0000, 16'h0000, 1'b1);
        #1;
        chk("resp_valid", 16'h0001, {15'h0000, resp_valid});
        chk("resp_kind", {14'h0000, k}, {14'h0000, resp_kind});
        chk("resp_value", {4'h0, e}, {4'h0, resp_value});
    endtask : q

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        #50000;
        n_fail++;
        stop_test();
    end

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        rst_b = 1'b0;
        hold_en = 1'b0;
        cond_in = 12'h000;
        n_fail = 0;
        n_checks = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        q(ssf_pkg::SSF_OP_MASK_Q, 2'h1, 12'h000);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NUM, 16'h0018,
                              16'h0000, 1'b1);
        q(ssf_pkg::SSF_OP_MASK_Q, 2'h1, 12'h018);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_ALL, 16'h0000,
                              16'h0000, 1'b1);
        q(ssf_pkg::SSF_OP_MASK_Q, 2'h1, 12'hffb);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NONE, 16'h0000,
                              16'h0000, 1'b1);
        q(ssf_pkg::SSF_OP_MASK_Q, 2'h1, 12'h000);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NAME, 16'h0001,
                              16'h0000, 1'b0);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_REPORTING_MASK_QUERY_NAME, 16'h0000,
                              16'h0000, 1'b1);
        q(ssf_pkg::SSF_OP_MASK_Q, 2'h1, 12'h003);
        $display("done mask tests");
        // Bit 2 is unused, so it must never show
        @(posedge ref_clk);
        cond_in <= 12'h01f;
        repeat (6) @(posedge ref_clk);
        q(ssf_pkg::SSF_OP_STATUS_Q, 2'h0, 12'h01b);
        q(ssf_pkg::SSF_OP_FAULT_Q, 2'h3, 12'h003);
        @(posedge ref_clk);
        cond_in <= 12'h000;
        repeat (6) @(posedge ref_clk);
        q(ssf_pkg::SSF_OP_STATUS_Q, 2'h0, 12'h000);
        q(ssf_pkg::SSF_OP_ACCUM_Q, 2'h2, 12'h01b);
        q(ssf_pkg::SSF_OP_ACCUM_Q, 2'h2, 12'h000);
        $display("done condition tests");
        u_ssf_host_model.send(ssf_pkg::SSF_OP_SET_V, 16'h0042,
                              16'h0000, 1'b1);
        #1;
        chk("v_prog", 16'h0042, v_prog);
        @(posedge ref_clk);
        hold_en <= 1'b1;
        u_ssf_host_model.send(ssf_pkg::SSF_OP_SET_V, 16'h0123,
                              16'h0000, 1'b1);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_SET_I, 16'h0456,
                              16'h0000, 1'b1);
        #1;
        chk("v_prog", 16'h0042, v_prog);
        chk("i_prog", 16'h0000, i_prog);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_APPLY_HELD, 16'h0000,
                              16'h0000, 1'b1);
        #1;
        chk("v_prog", 16'h0123, v_prog);
        chk("i_prog", 16'h0456, i_prog);
        @(posedge ref_clk);
        hold_en <= 1'b0;
        $display("done hold test");
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_HI, 16'h0000,
                              16'h0000, 1'b1);
        #1;
        chk("cmd_error", 16'h0001, {15'h0000, cmd_error});
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_COMPUTE, 16'h1000,
                              16'h9000, 1'b1);
        #1;
        chk("cmd_error", 16'h0001, {15'h0000, cmd_error});
        chk("v_slope", 16'h0000, v_slope);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_MODE, 16'h0001,
                              16'h0000, 1'b1);
        #1;
        chk("cal_mode", 16'h0001, {15'h0000, cal_mode});
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_HI, 16'h0000,
                              16'h0000, 1'b1);
        #1;
        chk("cal_drive_en", 16'h0001, {15'h0000, cal_drive_en});
        chk("cal_drive_val", `SSF_CAL_HI_VAL, cal_drive_val);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_LO, 16'h0000,
                              16'h0000, 1'b1);
        #1;
        chk("cal_drive_val", `SSF_CAL_LO_VAL, cal_drive_val);
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_COMPUTE, 16'h1000,
                              16'h9000, 1'b1);
        #1;
        chk("cmd_error", 16'h0000, {15'h0000, cmd_error});
        chk("v_slope", 16'h8000, v_slope);
        chk("v_offset", 16'h1000, v_offset);
        chk("cal_drive_en", 16'h0000, {15'h0000, cal_drive_en});
        u_ssf_host_model.send(ssf_pkg::SSF_OP_CAL_MODE, 16'h0000,
                              16'h0000, 1'b1);
        #1;
        chk("cal_mode", 16'h0000, {15'h0000, cal_mode});
        $display("done calibration tests");
        stop_test();
    end
endmodule : test_ssf_cmd_unit
